/* File: vbicw_inserter.sv */
// blanking-interval copy word, type b packet and widescreen inserter
`timescale 1ns/1ps
`default_nettype none
module vbicw_inserter
   import vbicw_pkg::*;
#(
   parameter int BIT_CYC = 4,
   parameter int RUNIN_BITS = 29,
   parameter logic [28:0] RUNIN_CODE = 29'h1F1C71C7,
   parameter int START_BITS = 24,
   parameter logic [23:0] START_CODE = 24'h1E3C1F
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic regWe,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   input wire logic [2:0] videoFormat,
   input wire logic [10:0] lineNumber,
   input wire logic evenField,
   input wire logic lineStart,
   input wire logic videoIn,
   output logic dataOut,
   output logic insertActive,
   output logic blankOut
);
   // ===================== registers =====================
   logic [7:0] edHdCopyControl, next_edHdCopyControl;
   logic [7:0] copyData [3];
   logic [7:0] next_copyData [3];
   logic [7:0] typebMem [17];
   logic [7:0] next_typebMem [17];
   logic [7:0] sdControl, next_sdControl;
   logic [7:0] sdData [2];
   logic [7:0] next_sdData [2];
   logic [7:0] blankControl, next_blankControl;
   logic [7:0] rdata, next_rdata;

   always_comb begin
      next_edHdCopyControl = edHdCopyControl;
      next_copyData = copyData;
      next_typebMem = typebMem;
      next_sdControl = sdControl;
      next_sdData = sdData;
      next_blankControl = blankControl;
      next_rdata = 8'h00;
      if (regWe) begin
         if (regAddr == REG_EDHD_COPY_CTRL) next_edHdCopyControl = regWdata;
         if (regAddr == REG_SD_SIG_CTRL) next_sdControl = regWdata;
         if (regAddr == REG_SD_L23_BLANK) next_blankControl = regWdata;
         if (regAddr >= REG_COPY_DATA0 && regAddr <= REG_COPY_DATA2)
            next_copyData[2'(regAddr - REG_COPY_DATA0)] = regWdata;
         if (regAddr >= REG_TYPEB_CTRL && regAddr <= REG_TYPEB_LAST)
            next_typebMem[5'(regAddr - REG_TYPEB_CTRL)] = regWdata;
         if (regAddr == REG_SD_SIG_DATA0 || regAddr == REG_SD_SIG_DATA1)
            next_sdData[1'(regAddr - REG_SD_SIG_DATA0)] = regWdata;
      end
      if (regAddr == REG_EDHD_COPY_CTRL) next_rdata = edHdCopyControl;
      else if (regAddr == REG_SD_SIG_CTRL) next_rdata = sdControl;
      else if (regAddr == REG_SD_L23_BLANK) next_rdata = blankControl;
      else if (regAddr >= REG_COPY_DATA0 && regAddr <= REG_COPY_DATA2)
         next_rdata = copyData[2'(regAddr - REG_COPY_DATA0)];
      else if (regAddr >= REG_TYPEB_CTRL && regAddr <= REG_TYPEB_LAST)
         next_rdata = typebMem[5'(regAddr - REG_TYPEB_CTRL)];
      else if (regAddr == REG_SD_SIG_DATA0 || regAddr == REG_SD_SIG_DATA1)
         next_rdata = sdData[1'(regAddr - REG_SD_SIG_DATA0)];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         edHdCopyControl <= 8'h00;
         copyData <= '{default: 8'h00};
         typebMem <= '{default: 8'h00};
         sdControl <= 8'h00;
         sdData <= '{default: 8'h00};
         blankControl <= 8'h00;
         rdata <= 8'h00;
      end else begin
         edHdCopyControl <= next_edHdCopyControl;
         copyData <= next_copyData;
         typebMem <= next_typebMem;
         sdControl <= next_sdControl;
         sdData <= next_sdData;
         blankControl <= next_blankControl;
         rdata <= next_rdata;
      end
   end
   assign regRdata = rdata;

   // ===================== line selection =====================
   // payload kinds: 0 none, 1 copy word, 2 type b, 3 widescreen
   logic [1:0] lineKind;
   logic [19:0] copyRaw;
   logic [TYPEB_BITS-1:0] typebRaw;
   logic copyEn, typebEn;

   always_comb begin
      // 625p uses only data 1 and 2 for the word
      if (videoFormat == FMT_625P)
         copyRaw = {copyData[1][3:0], copyData[2], 8'h00};
      else
         copyRaw = {copyData[0][3:0], copyData[1], copyData[2]};
      copyEn = edHdCopyControl[BIT_EDHD_COPY_EN];
      typebEn = typebMem[0][BIT_TYPEB_EN];
      lineKind = 2'h0;
      unique case (videoFormat)
         FMT_SD_NTSC: begin
            if (lineNumber == LN_SD_ODD && !evenField && sdControl[BIT_SD_ODD_EN])
               lineKind = 2'h1;
            if (lineNumber == LN_SD_EVEN && evenField && sdControl[BIT_SD_EVEN_EN])
               lineKind = 2'h1;
         end
         FMT_SD_PAL: begin
            if (lineNumber == LN_WIDE && sdControl[BIT_WIDE_EN])
               lineKind = 2'h3;
         end
         FMT_525P: begin
            if (lineNumber == LN_525P_COPY && copyEn) lineKind = 2'h1;
            if (lineNumber == LN_525P_TYPEB && typebEn) lineKind = 2'h2;
         end
         FMT_625P: begin
            if (lineNumber == LN_625P_COPY && copyEn) lineKind = 2'h1;
         end
         FMT_720P: begin
            if (lineNumber == LN_720P_COPY && copyEn) lineKind = 2'h1;
            if (lineNumber == LN_720P_TYPEB && typebEn) lineKind = 2'h2;
         end
         FMT_1080I: begin
            if ((lineNumber == LN_1080_COPY_A || lineNumber == LN_1080_COPY_B) && copyEn)
               lineKind = 2'h1;
            if ((lineNumber == LN_1080_TYPEB_A || lineNumber == LN_1080_TYPEB_B) && typebEn)
               lineKind = 2'h2;
         end
         default: lineKind = 2'h0;
      endcase
   end

   // packet bytes from 0x5F upward, lsb first in transmission order
   genvar gi;
   generate
      for (gi = 0; gi < 17; gi++) begin : g_typeb
         if (gi < 16) begin : g_full
            assign typebRaw[gi*8 +: 8] = typebMem[gi+1];
         end else begin : g_tail
            assign typebRaw[TYPEB_BITS-1:128] = typebMem[gi-16+1][5:0] ^ 6'h00;
         end
      end
   endgenerate

   // ===================== sequencer =====================
   localparam int SHW = 200;
   vbicw_state_e state, next_state;
   logic [SHW-1:0] shiftReg, next_shiftReg;
   logic [7:0] bitsLeft, next_bitsLeft;
   logic [7:0] crcIdx, next_crcIdx;
   logic [5:0] crc, next_crc;
   logic [7:0] bitCyc, next_bitCyc;
   logic [9:0] lineCyc, next_lineCyc;
   logic [1:0] kind, next_kind;
   logic out, next_out;
   logic act, next_act;
   logic blank, next_blank;
   logic wideLine, next_wideLine;
   logic crcBit;
   logic crcOn;

   always_comb begin
      next_state = state;
      next_shiftReg = shiftReg;
      next_bitsLeft = bitsLeft;
      next_crcIdx = crcIdx;
      next_crc = crc;
      next_bitCyc = bitCyc;
      next_kind = kind;
      next_wideLine = wideLine;
      next_lineCyc = (lineCyc == 10'h3FF) ? lineCyc : lineCyc + 10'h001;
      crcOn = (kind == 2'h2) ? typebMem[0][BIT_TYPEB_CRC_EN]
            : (videoFormat == FMT_SD_NTSC) ? sdControl[BIT_SD_CRC_EN]
            : edHdCopyControl[BIT_EDHD_CRC_EN];
      crcBit = shiftReg[crcIdx] ^ crc[5];
      if (lineStart) begin
         next_lineCyc = 10'h000;
         next_kind = lineKind;
         // blanking is decided per line, independent of the widescreen enable
         next_wideLine = (videoFormat == FMT_SD_PAL) && (lineNumber == LN_WIDE);
         next_bitCyc = 8'h00;
         next_crcIdx = 8'h00;
         next_crc = CRC_PRESET;
         next_shiftReg = '0;
         unique case (lineKind)
            2'h1: begin
               // reference pulse first, then 20 bits
               next_shiftReg[COPY_BITS:0] = {copyRaw, 1'b1};
               next_bitsLeft = 8'(COPY_BITS + 1);
            end
            2'h2: begin
               next_shiftReg[TYPEB_BITS-1:0] = typebRaw;
               next_bitsLeft = 8'(TYPEB_BITS);
            end
            2'h3: begin
               next_shiftReg[RUNIN_BITS+START_BITS+WIDE_BITS-1:0] =
                  {sdData[1][5:0], sdData[0], START_CODE, RUNIN_CODE};
               next_bitsLeft = 8'(RUNIN_BITS + START_BITS + WIDE_BITS);
            end
            default: next_bitsLeft = 8'h00;
         endcase
         next_state = (lineKind == 2'h0) ? ST_IDLE : ST_CRC;
      end else begin
         unique case (state)
            ST_IDLE: next_state = ST_IDLE;
            ST_CRC: begin
               // lsb-first serial check, one bit per clock
               if (!crcOn || kind == 2'h3) begin
                  next_state = ST_SEND;
               end else if ((kind == 2'h1 && crcIdx == 8'(COPY_DATA_BITS + 1)) ||
                            (kind == 2'h2 && crcIdx == 8'(TYPEB_DATA_BITS))) begin
                  if (kind == 2'h1)
                     next_shiftReg[COPY_BITS:COPY_DATA_BITS+1] = crc;
                  else
                     next_shiftReg[TYPEB_BITS-1:TYPEB_DATA_BITS] = crc;
                  next_state = ST_SEND;
               end else begin
                  if (kind == 2'h1 && crcIdx == 8'h00)
                     next_crcIdx = 8'h01; // skip the reference pulse
                  else begin
                     next_crc = {crc[4:0], 1'b0} ^ (crcBit ? 6'h03 : 6'h00);
                     next_crc[0] = crcBit;
                     next_crcIdx = crcIdx + 8'h01;
                  end
               end
            end
            ST_WAIT: next_state = ST_SEND;
            ST_SEND: begin
               if (bitCyc == 8'(BIT_CYC - 1)) begin
                  next_bitCyc = 8'h00;
                  next_shiftReg = {1'b0, shiftReg[SHW-1:1]};
                  next_bitsLeft = bitsLeft - 8'h01;
                  if (bitsLeft == 8'h01) next_state = ST_IDLE;
               end else next_bitCyc = bitCyc + 8'h01;
            end
            default: next_state = ST_IDLE;
         endcase
      end
      // the selected line's data region is replaced; the blanked part of line 23 is driven low
      next_act = (next_state == ST_SEND);
      next_out = next_act ? next_shiftReg[0] : videoIn;
      // widescreen part of line 23 may be blanked; tail is video
      next_blank = next_wideLine && blankControl[BIT_L23_BLANK] &&
                   (next_lineCyc < 10'(WIDE_VIDEO_CYC));
      if (next_kind == 2'h3 && next_lineCyc >= 10'(WIDE_VIDEO_CYC)) begin
         next_act = 1'b0;
         next_out = videoIn;
      end
      if (next_blank) next_out = 1'b0;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ST_IDLE;
         shiftReg <= '0;
         bitsLeft <= 8'h00;
         crcIdx <= 8'h00;
         crc <= CRC_PRESET;
         bitCyc <= 8'h00;
         lineCyc <= 10'h000;
         kind <= 2'h0;
         wideLine <= 1'b0;
         out <= 1'b0;
         act <= 1'b0;
         blank <= 1'b0;
      end else begin
         state <= next_state;
         shiftReg <= next_shiftReg;
         bitsLeft <= next_bitsLeft;
         crcIdx <= next_crcIdx;
         crc <= next_crc;
         bitCyc <= next_bitCyc;
         lineCyc <= next_lineCyc;
         kind <= next_kind;
         wideLine <= next_wideLine;
         out <= next_out;
         act <= next_act;
         blank <= next_blank;
      end
   end

   assign dataOut = out;
   assign insertActive = act;
   assign blankOut = blank;
endmodule
`default_nettype wire

/* File: vbicw_inserter_asserts.sv */
// port assertions for the blanking-interval inserter
`timescale 1ns/1ps
`default_nettype none
module vbicw_inserter_asserts
   import vbicw_pkg::*;
#(
   parameter int BIT_CYC = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic regWe,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic [7:0] regRdata,
   input wire logic [2:0] videoFormat,
   input wire logic [10:0] lineNumber,
   input wire logic evenField,
   input wire logic lineStart,
   input wire logic videoIn,
   input wire logic dataOut,
   input wire logic insertActive,
   input wire logic blankOut
);
   // ==========
   // helper: cycles the insert flag has been high
   logic [9:0] runLen;
   logic [9:0] next_runLen;
   always_comb begin
      next_runLen = insertActive ? runLen + 10'h001 : 10'h000;
   end
   always_ff @(posedge clk) begin
      runLen <= rst ? 10'h000 : next_runLen;
   end
   default clocking dcb @(posedge clk);
   endclocking
   default disable iff (rst);
   // ==========
   // properties
   property p_rst_quiet;
      $fell(rst) |-> !insertActive && !dataOut && !blankOut;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("output active after reset");
   property p_idle_line;
      lineStart && lineNumber == 11'h064 |=> ##1 (!insertActive && dataOut == $past(videoIn))[*4];
   endproperty
   a_idle_line: assert property (p_idle_line) else $error("idle line not passed through");
   property p_pal_nocopy;
      lineStart && videoFormat == FMT_SD_PAL && lineNumber == LN_SD_ODD |=> ##1 (!insertActive)[*6];
   endproperty
   a_pal_nocopy: assert property (p_pal_nocopy) else $error("copy word sent in pal");
   property p_wide_ntsc;
      lineStart && videoFormat == FMT_SD_NTSC && lineNumber == LN_WIDE |=> ##1 (!insertActive)[*6];
   endproperty
   a_wide_ntsc: assert property (p_wide_ntsc) else $error("widescreen sent in ntsc");
   property p_ref_pulse;
      $rose(insertActive) && videoFormat == FMT_SD_NTSC |-> dataOut[*4];
   endproperty
   a_ref_pulse: assert property (p_ref_pulse) else $error("reference pulse wrong");
   property p_sd_len;
      $fell(insertActive) && videoFormat == FMT_SD_NTSC |-> runLen == 10'(21 * BIT_CYC);
   endproperty
   a_sd_len: assert property (p_sd_len) else $error("sd copy length wrong");
   property p_read;
      (regWe && regAddr == REG_COPY_DATA2 ##1 !regWe && regAddr == REG_COPY_DATA2)
         |=> regRdata == $past(regWdata, 2);
   endproperty
   a_read: assert property (p_read) else $error("register read back wrong");
   property p_blank_zero;
      blankOut |-> !dataOut;
   endproperty
   a_blank_zero: assert property (p_blank_zero) else $error("data during blanking");
   property p_blank_pal;
      blankOut |-> videoFormat == FMT_SD_PAL;
   endproperty
   a_blank_pal: assert property (p_blank_pal) else $error("blanking outside pal");
endmodule
bind vbicw_inserter vbicw_inserter_asserts #(.BIT_CYC(BIT_CYC)) chk (.clk(clk), .rst(rst),
   .regWe(regWe), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
   .videoFormat(videoFormat), .lineNumber(lineNumber), .evenField(evenField),
   .lineStart(lineStart), .videoIn(videoIn), .dataOut(dataOut),
   .insertActive(insertActive), .blankOut(blankOut));
`default_nettype wire

/* File: vbicw_inserter_tb_top.sv */
// self-checking bench for the blanking-interval inserter
`timescale 1ns/1ps
`default_nettype none
module vbicw_inserter_tb_top
   import vbicw_pkg::*;
;
   typedef struct {logic [2:0] f; logic [10:0] ln; logic ev; logic [7:0] c99; logic [7:0] c32;
      logic [19:0] w; int n;} vbicw_row_s;
   logic clk = 1'b0;
   logic videoIn = 1'b0;
   logic rst, regWe, evenField, lineStart, dataOut, insertActive, blankOut;
   logic [7:0] regAddr, regWdata, regRdata, nBits;
   logic [2:0] videoFormat;
   logic [10:0] lineNumber;
   logic [199:0] bits;
   int nMismatch = 0;
   int testsRun = 0;
   vbicw_row_s rows[12] = '{
      '{FMT_SD_NTSC, LN_SD_ODD, 0, 8'h20, 8'h00, 20'hC5A96, 21},  // odd line, crc off
      '{FMT_SD_NTSC, LN_SD_EVEN, 1, 8'h50, 8'h00, 20'hC5A96, 21}, // even, crc on
      '{FMT_SD_NTSC, LN_SD_EVEN, 1, 8'h20, 8'h00, 20'hC5A96, 0},  // odd only
      '{FMT_SD_NTSC, LN_SD_ODD, 0, 8'h60, 8'h00, 20'hC5A96, 21},  // both fields
      '{FMT_SD_PAL, LN_SD_ODD, 0, 8'h60, 8'h00, 20'hC5A96, 0},
      '{FMT_525P, LN_525P_COPY, 0, 8'h00, 8'h40, 20'hC5A96, 21},
      '{FMT_525P, LN_525P_COPY, 0, 8'h00, 8'h00, 20'hC5A96, 0},
      '{FMT_625P, LN_625P_COPY, 0, 8'h00, 8'hC0, 20'hA9600, 21},
      '{FMT_720P, LN_720P_COPY, 0, 8'h00, 8'h40, 20'hC5A96, 21},
      '{FMT_1080I, LN_1080_COPY_A, 0, 8'h00, 8'hC0, 20'hC5A96, 21},
      '{FMT_1080I, LN_1080_COPY_B, 1, 8'h00, 8'h40, 20'hC5A96, 21},
      '{FMT_720P, LN_720P_TYPEB, 0, 8'h00, 8'h40, 20'hC5A96, 0}};
   logic [2:0] tbFmt[4] = '{FMT_525P, FMT_720P, FMT_1080I, FMT_1080I};
   logic [10:0] tbLn[4] = '{LN_525P_TYPEB, LN_720P_TYPEB, LN_1080_TYPEB_A, LN_1080_TYPEB_B};
   logic tbCrc[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   vbicw_inserter uut (.clk(clk), .rst(rst), .regWe(regWe), .regAddr(regAddr),
      .regWdata(regWdata), .regRdata(regRdata), .videoFormat(videoFormat),
      .lineNumber(lineNumber), .evenField(evenField), .lineStart(lineStart), .videoIn(videoIn),
      .dataOut(dataOut), .insertActive(insertActive), .blankOut(blankOut));
   vbicw_tv_model tv (.clk(clk), .rst(rst), .lineStart(lineStart), .insertActive(insertActive),
      .dataOut(dataOut), .bits(bits), .nBits(nBits));
   always #50 clk = ~clk;
   always @(negedge clk) videoIn <= ~videoIn;
   // ==========
   // tasks
   function automatic logic [5:0] crc6(input logic [127:0] d, input int n);
      logic [5:0] c;
      logic fb;
      c = CRC_PRESET;
      for (int i = 0; i < n; i++) begin
         fb = d[i] ^ c[5];
         c = {c[4:0], fb} ^ {4'h0, fb, 1'b0};
      end
      return c;
   endfunction
   task automatic chk(input logic [133:0] seen, input logic [133:0] exp, input string what);
      testsRun++;
      if (seen !== exp) begin
         nMismatch++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regWe = 1'b1;
      regAddr = a;
      regWdata = d;
      @(negedge clk);
      regWe = 1'b0;
      @(negedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      regAddr = a;
      @(negedge clk);
      chk(134'(regRdata), 134'(e), "read");
   endtask
   task automatic startLine(input logic [2:0] f, input logic [10:0] ln, input logic ev);
      @(negedge clk);
      videoFormat = f;
      lineNumber = ln;
      evenField = ev;
      lineStart = 1'b1;
      @(negedge clk);
      lineStart = 1'b0;
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", testsRun, nMismatch);
      if (nMismatch == 0 && testsRun > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ==========
   // sequence
   initial begin
      logic [19:0] e;
      logic seen;
      logic [127:0] pkt;
      {rst, regWe, regAddr, regWdata, videoFormat, lineNumber, evenField, lineStart} = '0;
      rst = 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      rd(REG_SD_SIG_CTRL, 8'h00);
      wr(8'h00, 8'hFF);
      rd(8'h00, 8'h00);
      wr(REG_COPY_DATA0, 8'h3C);
      wr(REG_COPY_DATA1, 8'h5A);
      wr(REG_COPY_DATA2, 8'h96);
      rd(REG_COPY_DATA2, 8'h96);
      foreach (rows[i]) begin
         wr(REG_SD_SIG_CTRL, rows[i].c99);
         wr(REG_EDHD_COPY_CTRL, rows[i].c32);
         startLine(rows[i].f, rows[i].ln, rows[i].ev);
         repeat (800) @(negedge clk);
         e = rows[i].w;
         if (rows[i].c99[4] || rows[i].c32[7]) e[19:14] = crc6(128'(e[13:0]), 14);
         chk(134'(nBits), 134'(rows[i].n), "count");
         if (rows[i].n != 0) chk(134'(bits[20:0]), 134'({e, 1'b1}), "word");
         $display("row %0d done", i);
      end
      wr(REG_EDHD_COPY_CTRL, 8'h00);
      for (int j = 0; j < 16; j++) begin
         pkt[j*8 +: 8] = 8'(8'h11 * j + 8'h07);
         wr(8'(REG_TYPEB_CTRL + 8'(j + 1)), pkt[j*8 +: 8]);
      end
      foreach (tbFmt[k]) begin
         wr(REG_TYPEB_CTRL, {6'h00, tbCrc[k], 1'b1});
         startLine(tbFmt[k], tbLn[k], 1'b0);
         repeat (800) @(negedge clk);
         chk(134'(nBits), 134'(TYPEB_BITS), "typeb count");
         chk(134'(bits[127:0]), 134'(pkt), "typeb data");
         if (tbCrc[k]) chk(134'(bits[133:128]), 134'(crc6(pkt, 128)), "typeb crc");
         $display("packet %0d done", k);
      end
      wr(REG_TYPEB_CTRL, 8'h00);
      wr(REG_SD_SIG_DATA0, 8'h08); // full-format aspect code
      wr(REG_SD_SIG_DATA1, 8'h20); // copy restricted, reserved bit clear
      wr(REG_SD_SIG_CTRL, 8'h80);
      startLine(FMT_SD_PAL, LN_WIDE, 1'b0);
      repeat (800) @(negedge clk);
      chk(134'(bits[nBits - 14 +: 14]), 134'(14'h2008), "wide word");
      startLine(FMT_SD_NTSC, LN_WIDE, 1'b0);
      repeat (800) @(negedge clk);
      chk(134'(nBits), 134'(0), "wide in ntsc");
      $display("widescreen done");
      wr(REG_SD_SIG_CTRL, 8'h00);
      wr(REG_SD_L23_BLANK, 8'h80);
      startLine(FMT_SD_PAL, LN_WIDE, 1'b0);
      seen = 1'b0;
      repeat (400) begin
         @(negedge clk);
         seen |= blankOut;
      end
      chk(134'(seen), 134'(1'b1), "blank seen");
      repeat (40) @(negedge clk);
      @(posedge clk);
      #1;
      chk(134'(dataOut), 134'(videoIn), "late video");
      repeat (400) @(negedge clk);
      $display("blanking done");
      // a new line start mid-word must cut the word short
      wr(REG_SD_L23_BLANK, 8'h00);
      wr(REG_EDHD_COPY_CTRL, 8'h40);
      startLine(FMT_720P, LN_720P_COPY, 1'b0);
      repeat (30) @(negedge clk);
      chk(134'(insertActive), 134'(1'b1), "mid word");
      startLine(FMT_720P, 11'h064, 1'b0);
      repeat (3) @(negedge clk);
      chk(134'(insertActive), 134'(1'b0), "abort");
      $display("abort done");
      end_sim();
   end
   initial begin
      repeat (60000) @(posedge clk);
      nMismatch++;
      end_sim();
   end
endmodule
`default_nettype wire

/* File: vbicw_pkg.sv */
// constants for the blanking-interval copy and widescreen inserter
package vbicw_pkg;
   // ===================== register offsets =====================
   localparam logic [7:0] REG_EDHD_COPY_CTRL = 8'h32;
   localparam logic [7:0] REG_COPY_DATA0 = 8'h41;
   localparam logic [7:0] REG_COPY_DATA1 = 8'h42;
   localparam logic [7:0] REG_COPY_DATA2 = 8'h43;
   localparam logic [7:0] REG_TYPEB_CTRL = 8'h5E;
   localparam logic [7:0] REG_TYPEB_LAST = 8'h6E;
   localparam logic [7:0] REG_SD_SIG_CTRL = 8'h99;
   localparam logic [7:0] REG_SD_SIG_DATA0 = 8'h9A;
   localparam logic [7:0] REG_SD_SIG_DATA1 = 8'h9B;
   localparam logic [7:0] REG_SD_L23_BLANK = 8'hA1;
   // ===================== field positions =====================
   localparam int BIT_EDHD_COPY_EN = 6;
   localparam int BIT_EDHD_CRC_EN = 7;
   localparam int BIT_TYPEB_EN = 0;
   localparam int BIT_TYPEB_CRC_EN = 1;
   localparam int BIT_SD_CRC_EN = 4;
   localparam int BIT_SD_ODD_EN = 5;
   localparam int BIT_SD_EVEN_EN = 6;
   localparam int BIT_WIDE_EN = 7;
   localparam int BIT_L23_BLANK = 7;
   // ===================== word sizes =====================
   localparam int COPY_BITS = 20;
   localparam int COPY_DATA_BITS = 14;
   localparam int CHECK_BITS = 6;
   localparam int TYPEB_BITS = 134;
   localparam int TYPEB_DATA_BITS = 128;
   localparam int WIDE_BITS = 14;
   localparam logic [5:0] CRC_PRESET = 6'h3F;
   // ===================== line numbers =====================
   localparam logic [10:0] LN_SD_ODD = 11'h014;    // 20
   localparam logic [10:0] LN_SD_EVEN = 11'h11B;   // 283
   localparam logic [10:0] LN_525P_COPY = 11'h029; // 41
   localparam logic [10:0] LN_525P_TYPEB = 11'h028; // 40
   localparam logic [10:0] LN_625P_COPY = 11'h02B; // 43
   localparam logic [10:0] LN_720P_COPY = 11'h018; // 24
   localparam logic [10:0] LN_720P_TYPEB = 11'h017; // 23
   localparam logic [10:0] LN_1080_COPY_A = 11'h013; // 19
   localparam logic [10:0] LN_1080_COPY_B = 11'h246; // 582
   localparam logic [10:0] LN_1080_TYPEB_A = 11'h012; // 18
   localparam logic [10:0] LN_1080_TYPEB_B = 11'h245; // 581
   localparam logic [10:0] LN_WIDE = 11'h017;      // 23
   // ===================== timing =====================
   localparam real CLK_NS = 100.0;
   localparam real WIDE_VIDEO_US = 42.5;
   localparam int WIDE_VIDEO_CYC = int'((WIDE_VIDEO_US * 1000.0) / CLK_NS);
   // ===================== video formats and sequencer states =====================
   typedef enum logic [2:0] {
      FMT_SD_NTSC = 3'h0,
      FMT_SD_PAL = 3'h1,
      FMT_525P = 3'h2,
      FMT_625P = 3'h3,
      FMT_720P = 3'h4,
      FMT_1080I = 3'h5
   } vbicw_fmt_e;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_CRC = 4'h2,
      ST_WAIT = 4'h4,
      ST_SEND = 4'h8
   } vbicw_state_e;
endpackage

/* File: vbicw_tv_model.sv */
// receiver model: slices inserted bits at mid-bit
`timescale 1ns/1ps
`default_nettype none
module vbicw_tv_model #(
   parameter int BIT_CYC = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic lineStart,
   input wire logic insertActive,
   input wire logic dataOut,
   output logic [199:0] bits,
   output logic [7:0] nBits
);
   logic [7:0] phase;
   // mid-bit sampling tolerates any start latency after the line begins
   always_ff @(posedge clk) begin
      if (rst || lineStart) begin
         nBits <= 8'h00;
         phase <= 8'h00;
         bits <= '0;
      end else if (!insertActive) begin
         phase <= 8'h00;
      end else begin
         phase <= (phase == 8'(BIT_CYC - 1)) ? 8'h00 : phase + 8'h01;
         if (phase == 8'(BIT_CYC / 2)) begin
            bits[nBits] <= dataOut;
            nBits <= nBits + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire
